// *** asrc_host.sv ***
// Host controller that runs single read and write cycles on the memory pins.
// Assumes the memory pins are wired through a testbench that resolves the data bus.
`timescale 1ns/1ps
module asrc_host (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Request side
    input wire logic req_valid_i,
    input wire asrc_pkg::asrc_req_t req_i,
    output logic req_ready_o,
    output logic rsp_valid_o,
    output logic [asrc_pkg::DATA_W-1:0] rsp_data_o,
    // Memory pins
    output logic [asrc_pkg::ADDR_W-1:0] word_address_o,
    output asrc_pkg::asrc_ctl_t mem_ctl_o,
    input wire logic [asrc_pkg::DATA_W-1:0] data_bus_i,
    output logic [asrc_pkg::DATA_W-1:0] data_bus_o,
    output logic data_bus_oe_o
);
    import asrc_pkg::*;

    // ==========================================================
    // Input synchroniser
    logic [DATA_W-1:0] bus_s1;
    logic [DATA_W-1:0] bus_s2;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_s1 <= '0;
            bus_s2 <= '0;
        end else begin
            bus_s1 <= data_bus_i;
            bus_s2 <= bus_s1;
        end
    end

    // ==========================================================
    // Sequencer
    typedef enum logic [2:0] {S_IDLE, S_SETUP, S_READ, S_FLOAT, S_WRITE, S_RECOV} asrc_state_t;

    asrc_state_t state, next_state;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic [ADDR_W-1:0] next_addr;
    asrc_ctl_t next_ctl;
    logic [DATA_W-1:0] next_wdata;
    logic next_oe;
    logic next_ready;
    logic next_rsp_valid;
    logic [DATA_W-1:0] next_rsp_data;
    logic is_write, next_is_write;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_addr = word_address_o;
        next_ctl = mem_ctl_o;
        next_wdata = data_bus_o;
        next_oe = data_bus_oe_o;
        next_ready = 1'b0;
        next_rsp_valid = 1'b0;
        next_rsp_data = rsp_data_o;
        next_is_write = is_write;
        unique case (state)
            S_IDLE: begin
                next_ready = 1'b1;
                if (req_valid_i && req_ready_o) begin
                    // Address settles a cycle before select goes active
                    next_addr = req_i.addr;
                    next_wdata = req_i.wdata;
                    next_is_write = req_i.write;
                    next_ready = 1'b0;
                    next_state = S_SETUP;
                end
            end
            S_SETUP: begin
                next_ctl.chip_select_lo_n = 1'b0;
                next_ctl.chip_select_hi = 1'b1;
                if (is_write) begin
                    // Output enable kept high and select with write low: memory floats
                    next_ctl.write_enable_n = 1'b0;
                    next_oe = 1'b1;
                    next_cnt = CNT_ONE;
                    next_state = S_WRITE;
                end else begin
                    next_ctl.output_enable_n = 1'b0;
                    next_cnt = CNT_ONE;
                    next_state = S_READ;
                end
            end
            S_READ: begin
                next_cnt = cnt + CNT_ONE;
                if (cnt == CNT_W'(READ_CYC)) begin
                    next_rsp_data = bus_s2;
                    next_rsp_valid = 1'b1;
                    next_ctl = CTL_IDLE;
                    next_cnt = CNT_ONE;
                    next_state = S_FLOAT;
                end
            end
            S_FLOAT: begin
                // Memory needs time to release the bus before the next drive
                next_cnt = cnt + CNT_ONE;
                if (cnt == CNT_W'(FLOAT_CYC)) begin
                    next_state = S_IDLE;
                    next_ready = 1'b1;
                end
            end
            S_WRITE: begin
                next_cnt = cnt + CNT_ONE;
                if (cnt == CNT_W'(WRITE_CYC)) begin
                    next_ctl = CTL_IDLE;
                    next_cnt = CNT_ONE;
                    next_state = S_RECOV;
                end
            end
            S_RECOV: begin
                // Data held a cycle past write end, then released
                next_oe = 1'b0;
                next_state = S_IDLE;
                next_ready = 1'b1;
            end
            default: next_state = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= S_IDLE;
            cnt <= CNT_ZERO;
            word_address_o <= '0;
            mem_ctl_o <= CTL_IDLE;
            data_bus_o <= '0;
            data_bus_oe_o <= 1'b0;
            req_ready_o <= 1'b0;
            rsp_valid_o <= 1'b0;
            rsp_data_o <= '0;
            is_write <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            word_address_o <= next_addr;
            mem_ctl_o <= next_ctl;
            data_bus_o <= next_wdata;
            data_bus_oe_o <= next_oe;
            req_ready_o <= next_ready;
            rsp_valid_o <= next_rsp_valid;
            rsp_data_o <= next_rsp_data;
            is_write <= next_is_write;
        end
    end

    // ==========================================================
    // Checks
    logic selected;
    assign selected = !mem_ctl_o.chip_select_lo_n && mem_ctl_o.chip_select_hi;

    a_no_bus_fight: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        data_bus_oe_o |-> mem_ctl_o.output_enable_n)
        else $error("host drives bus while memory output enabled");
    a_addr_before_select: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(selected) |-> $stable(word_address_o))
        else $error("address changed as select went active");
    a_write_pulse_len: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $fell(mem_ctl_o.write_enable_n) |-> (!mem_ctl_o.write_enable_n && selected)[*3])
        else $error("write pulse shorter than three cycles");
    a_write_data_valid: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(mem_ctl_o.write_enable_n) |-> $past(data_bus_oe_o) && $past(data_bus_oe_o, 2))
        else $error("write data not driven before write end");
    a_write_addr_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !mem_ctl_o.write_enable_n |-> $stable(word_address_o))
        else $error("address moved during write");
    a_write_oe_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !mem_ctl_o.write_enable_n |-> mem_ctl_o.output_enable_n)
        else $error("output enable low during write");
    a_read_response: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $fell(mem_ctl_o.output_enable_n) |-> ##6 rsp_valid_o)
        else $error("read answer not six cycles after output enable");
    a_float_gap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(mem_ctl_o.output_enable_n) |-> (!data_bus_oe_o)[*2])
        else $error("host drove bus too soon after read");

    // ==========================================================
    // Pin shape during reads and around writes
    a_select_pair: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        mem_ctl_o.chip_select_lo_n == !mem_ctl_o.chip_select_hi)
        else $error("chip selects out of step");
    a_read_select_len: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $fell(mem_ctl_o.output_enable_n) |-> (!mem_ctl_o.output_enable_n && selected)[*6])
        else $error("read select window shorter than six cycles");
    a_rsp_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rsp_valid_o |=> !rsp_valid_o)
        else $error("read answer longer than one cycle");
    a_addr_during_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !mem_ctl_o.output_enable_n |-> $stable(word_address_o))
        else $error("address moved during read");
    a_write_data_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !mem_ctl_o.write_enable_n |-> $stable(data_bus_o))
        else $error("write data moved during write");
    a_oe_release: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(mem_ctl_o.write_enable_n) |-> data_bus_oe_o ##1 !data_bus_oe_o)
        else $error("write data not held one cycle past write end");
    a_ready_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        req_ready_o |-> !selected)
        else $error("ready while memory selected");
endmodule : asrc_host

// *** asrc_pkg.sv ***
// Package for the asynchronous static memory host controller.
// Assumes a single 250 MHz clock; all times are in ns.
package asrc_pkg;
    // ==========================================================
    // Geometry
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;

    // ==========================================================
    // Timing in ns and derived cycle counts
    localparam int CLK_PERIOD_NS = 4;
    localparam int SELECT_TO_DATA_DELAY_NS = 12;
    localparam int OUTPUT_ENABLE_TO_DATA_DELAY_NS = 6;
    localparam int DESELECT_TO_OUTPUT_FLOAT_NS = 6;
    localparam int OUTPUT_DISABLE_TO_FLOAT_NS = 6;
    localparam int ADDRESS_VALID_TO_WRITE_END_NS = 10;
    localparam int SELECT_TO_WRITE_END_NS = 10;
    localparam int DATA_SETUP_TO_WRITE_END_NS = 7;
    localparam int WRITE_PULSE_NS = 9;
    localparam int CYCLE_TIME_NS = 12;

    function automatic int ns_to_cyc_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : ns_to_cyc_up

    // Read wait covers select access, the edge on which data may just settle,
    // and both synchroniser stages, so the sampled word is always settled
    localparam int READ_MARGIN_CYC = 3;
    localparam int READ_CYC = ns_to_cyc_up(SELECT_TO_DATA_DELAY_NS) + READ_MARGIN_CYC;
    // Write low time covers address, select, data set-up and pulse width
    localparam int WRITE_CYC = ns_to_cyc_up(ADDRESS_VALID_TO_WRITE_END_NS);
    // Turnaround after a read before the host may drive the bus
    localparam int FLOAT_CYC = ns_to_cyc_up(OUTPUT_DISABLE_TO_FLOAT_NS);
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } asrc_req_t;

    typedef struct packed {
        logic chip_select_lo_n;
        logic chip_select_hi;
        logic output_enable_n;
        logic write_enable_n;
    } asrc_ctl_t;

    localparam asrc_ctl_t CTL_IDLE = 4'b1011;
endpackage : asrc_pkg

// *** asrc_mem_model.sv ***
// Behavioural model of the asynchronous static memory on the host pins.
// Assumes the testbench resolves the shared data bus from both enables.
`timescale 1ns/1ps
module asrc_mem_model (
    // Memory pins
    input wire logic [asrc_pkg::ADDR_W-1:0] word_address_i,
    input wire asrc_pkg::asrc_ctl_t ctl_i,
    input wire logic [asrc_pkg::DATA_W-1:0] bus_i,
    // Read drive
    output logic [asrc_pkg::DATA_W-1:0] bus_o,
    output logic bus_oe_o
);
    import asrc_pkg::*;
    // ==========================================================
    // Array and mode decode
    logic [DATA_W-1:0] mem [2**ADDR_W];
    logic sel;
    logic rd;
    logic wr;
    assign sel = !ctl_i.chip_select_lo_n && ctl_i.chip_select_hi;
    assign rd = sel && !ctl_i.output_enable_n && ctl_i.write_enable_n;
    assign wr = sel && !ctl_i.write_enable_n;
    // ==========================================================
    // Store, drive late, release at once
    always @(negedge wr) begin
        mem[word_address_i] = bus_i;
    end
    always @(rd) begin
        if (rd !== 1'b1) begin
            bus_oe_o = 1'b0;
        end else begin
            #3 bus_oe_o = rd;
        end
    end
    initial bus_o = 8'h00;
    // Each change schedules its own glitch and settle, so none is missed
    always @(word_address_i, rd) begin
        bus_o <= #3 ~mem[word_address_i];
        bus_o <= #12 mem[word_address_i];
    end
endmodule : asrc_mem_model

// *** tb.sv ***
// Self-checking testbench for the static memory host controller.
// Assumes the memory model stands on the pins; bus resolved here.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb;
    import asrc_pkg::*;
    // ==========================================================
    // Clock, pins and bus
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic req_valid_i = 1'b0;
    asrc_req_t req_i = '0;
    logic req_ready_o, rsp_valid_o, data_bus_oe_o, mem_oe;
    logic [DATA_W-1:0] rsp_data_o, data_bus_o, mem_o, bus;
    logic [DATA_W-1:0] float_val = 8'h00;
    logic [ADDR_W-1:0] word_address_o;
    asrc_ctl_t mem_ctl_o;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    always #2 clk_i = ~clk_i;
    assign bus = data_bus_oe_o ? data_bus_o : (mem_oe ? mem_o : float_val);
    always @(posedge clk_i) begin
        float_val <= rst_n_i ? ~bus : 8'h00;
        cyc++;
        if (rst_n_i) `CHK("bus_clash", 1'b0, data_bus_oe_o & mem_oe)
        if (cyc == 3000) begin
            error_cnt++;
            end_of_test();
        end
    end
    asrc_host i_asrc_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
        .req_i(req_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
        .rsp_data_o(rsp_data_o), .word_address_o(word_address_o), .mem_ctl_o(mem_ctl_o),
        .data_bus_i(bus), .data_bus_o(data_bus_o), .data_bus_oe_o(data_bus_oe_o));
    asrc_mem_model i_asrc_mem_model (.word_address_i(word_address_o), .ctl_i(mem_ctl_o),
        .bus_i(bus), .bus_o(mem_o), .bus_oe_o(mem_oe));
    // ==========================================================
    // One transfer; hold_v presents a request that must be refused
    task automatic xfer(input logic wr, input logic [16:0] a, input logic [7:0] d,
        input logic hold_v);
        int last;
        last = wr ? 5 : 9;
        while (req_ready_o !== 1'b1 && cyc < 3000) begin
            @(posedge clk_i);
            #1;
        end
        req_valid_i = 1'b1;
        req_i = '{wr, a, d};
        @(posedge clk_i);
        #1;
        req_valid_i = hold_v;
        req_i = '{1'b1, 17'h0_0020, 8'h22};
        for (int k = 1; k <= last; k++) begin
            @(posedge clk_i);
            #1;
            if (k == last - 1) req_valid_i = 1'b0;
            `CHK("ready", (k == last), req_ready_o)
            if (k == 2) begin
                `CHK("ctl", (wr ? 4'h6 : 4'h5), mem_ctl_o)
                `CHK("addr", a, word_address_o)
                `CHK("oe", wr, data_bus_oe_o)
            end
            if (wr && k == 4) `CHK("wdata", d, bus)
            if (k == (wr ? 4 : 7)) `CHK("ctl_end", CTL_IDLE, mem_ctl_o)
            if (wr && k == 5) `CHK("oe_off", 1'b0, data_bus_oe_o)
            if (!wr) `CHK("rsp_valid", (k == 7), rsp_valid_o)
            if (!wr && k == 7) `CHK("rdata", d, rsp_data_o)
        end
    endtask : xfer
    // Reset in the middle of a write, then the host must come back idle
    task automatic mid_reset();
        while (req_ready_o !== 1'b1 && cyc < 3000) begin
            @(posedge clk_i);
            #1;
        end
        req_valid_i = 1'b1;
        req_i = '{1'b1, 17'h0_0040, 8'h77};
        @(posedge clk_i);
        #1;
        req_valid_i = 1'b0;
        @(posedge clk_i);
        #1;
        rst_n_i = 1'b0;
        #1;
        `CHK("mid_ctl", CTL_IDLE, mem_ctl_o)
        `CHK("mid_oe", 1'b0, data_bus_oe_o)
        `CHK("mid_rdy", 1'b0, req_ready_o)
        @(posedge clk_i);
        #1;
        rst_n_i = 1'b1;
        @(posedge clk_i);
        #1;
        `CHK("mid_rdy_back", 1'b1, req_ready_o)
        `CHK("mid_ctl_back", CTL_IDLE, mem_ctl_o)
    endtask : mid_reset
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test
    // ==========================================================
    // Main sequence
    initial begin
        repeat (8) @(posedge clk_i);
        #1;
        `CHK("rst_ctl", CTL_IDLE, mem_ctl_o)
        `CHK("rst_rdy", 1'b0, req_ready_o)
        rst_n_i = 1'b1;
        xfer(1'b1, 17'h0_0000, 8'hA5, 1'b0);
        xfer(1'b1, 17'h1_FFFF, 8'h5A, 1'b0);
        xfer(1'b0, 17'h1_FFFF, 8'h5A, 1'b0);
        xfer(1'b0, 17'h0_0000, 8'hA5, 1'b0);
        xfer(1'b1, 17'h0_0020, 8'h11, 1'b0);
        xfer(1'b1, 17'h0_0010, 8'h33, 1'b1);
        mid_reset();
        xfer(1'b0, 17'h0_0020, 8'h11, 1'b0);
        xfer(1'b0, 17'h0_0010, 8'h33, 1'b0);
        `CHK("idle_ctl", CTL_IDLE, mem_ctl_o)
        end_of_test();
    end
endmodule : tb
